// ---- test/atx_host_model.sv ----
`timescale 1ns/1ps
// Host board side: switch inputs with pull-ups and host sense on line 1
module atx_host_model (
   // Clock
   input wire logic refClk,
   // Lines from the block
   input wire logic [4:0] gpioOut,
   input wire logic [4:0] gpioOe,
   // Host state on line 1
   input wire logic altSense,
   // Resolved levels and press count
   output logic [4:0] gpioIn,
   output logic [7:0] pwrPresses = 8'h00
);
   logic oeLast = 1'b0; // Power line enable last cycle
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         gpioIn[i] = gpioOe[i] ? gpioOut[i] : 1'b1;
      end
      if (!gpioOe[1]) begin
         gpioIn[1] = altSense;
      end
   end
   // Counts power switch presses
   always @(posedge refClk) begin
      oeLast <= gpioOe[2];
      if (gpioOe[2] && !oeLast) begin
         pwrPresses <= pwrPresses + 8'h01;
      end
   end
endmodule

// ---- test/atx_keypad_chk.sv ----
`timescale 1ns/1ps
// Port-level checks of the keypad host power block
module atx_keypad_chk #(
   parameter int TICK_CYC = 20
) (
   // Clock and reset
   input wire logic refClk,
   input wire logic resetn,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdata,
   // Sense and lines
   input wire logic hostSense,
   input wire logic [4:0] gpioIn,
   input wire logic [4:0] gpioOut,
   input wire logic [4:0] gpioOe,
   // Module side
   input wire logic blankDisplay,
   input wire logic rebootReq
);
   logic [7:0] ctrlSh; // Shadow of the control register
   logic senseSel; // Host sense from the chosen source
   default clocking @(posedge refClk); endclocking
   default disable iff (!resetn);
   // Shadow follows control writes
   always_ff @(posedge refClk) begin
      if (!resetn) begin
         ctrlSh <= 8'h00;
      end else if (regWr && regAddr == atx_keypad_pkg::OFS_CTRL) begin
         ctrlSh <= regWdata[7:0];
      end
   end
   assign senseSel = ctrlSh[4] ? gpioIn[1] : hostSense;
   AST_BLANK_ON: assert property ((ctrlSh[3] && !senseSel) [*8] |-> blankDisplay)
      else $error("display not blanked while host off");
   AST_BLANK_OFF: assert property ((!ctrlSh[3] || senseSel) [*8] |-> !blankDisplay)
      else $error("display blanked without cause");
   AST_CMD_ON: assert property (regWr && regAddr == 4'h3 && regWdata[0] && gpioOe[3:2] == 2'b00
      |=> gpioOe[2] && gpioOut[2] == !ctrlSh[5]) else $error("power line not driven on command");
   AST_CMD_RST: assert property (regWr && regAddr == 4'h3 && regWdata[2:0] == 3'b100
      && gpioOe[3:2] == 2'b00 |=> gpioOe[3] && gpioOut[3] == ctrlSh[6])
      else $error("reset line not driven on command");
   AST_PWR_HOLD: assert property (ctrlSh[2:0] != 3'b000 && $rose(gpioOe[2]) |-> gpioOe[2] [*8])
      else $error("power drive too short");
   AST_LEVEL_STANDS: assert property (ctrlSh[2:0] != 3'b000 && gpioOe[2] && $past(gpioOe[2])
      |-> $stable(gpioOut[2])) else $error("power drive level changed");
   AST_ONE_ACTION: assert property (ctrlSh[2:0] != 3'b000 |-> !(gpioOe[2] && gpioOe[3]))
      else $error("power and reset driven together");
   AST_REBOOT_PULSE: assert property (rebootReq |=> !rebootReq)
      else $error("reboot request longer than a cycle");
   AST_RD_QUIET: assert property (!regRd |=> regRdata == 16'h0000)
      else $error("read data outside read cycle");
   AST_RD_CTRL: assert property (regRd && regAddr == 4'h0 |=> regRdata == {8'h00, ctrlSh})
      else $error("control readback wrong");
endmodule

// ---- test/test_atx_host_power_keypad_control.sv ----
`timescale 1ns/1ps
// Self-checking bench for the keypad host power block
module test_atx_host_power_keypad_control;
   localparam int TC = 20; // Short tick for simulation
   logic refClk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic keyEnter = 1'b0;
   logic keyCancel = 1'b0;
   logic hostSense = 1'b0;
   logic altSense = 1'b1;
   logic [15:0] regRdata;
   logic [4:0] gpioIn;
   logic [4:0] gpioOut;
   logic [4:0] gpioOe;
   logic blankDisplay;
   logic rebootReq;
   logic [7:0] pwrPresses;
   logic [15:0] rdat; // Last read data
   logic [15:0] cnt; // PWM high count
   logic [5:0] watch; // Waitable outputs
   int mismatches = 0;
   int totalChecks = 0;
   int cyc = 0;
   // Rows: address, write data, expected read
   localparam logic [35:0] ROWS [7] = '{36'h1_FC05_0005, 36'h2_FFE1_0001, 36'h3_0000_0000,
      36'h5_1280_0080, 36'h9_0040_0040, 36'hF_ABCD_0000, 36'h0_FF7F_007F};
   // Reset values: address, value
   localparam logic [19:0] RV [4] = '{20'h0_0000, 20'h1_0064, 20'h2_0000, 20'h5_0000};
   assign watch = {rebootReq, gpioOe};
   always #25 refClk = ~refClk;
   atx_host_power_keypad_control #(.TICK_CYC(TC)) atx_host_power_keypad_control_i (
      .refClk(refClk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .keyEnter(keyEnter),
      .keyCancel(keyCancel), .hostSense(hostSense), .gpioIn(gpioIn), .gpioOut(gpioOut),
      .gpioOe(gpioOe), .blankDisplay(blankDisplay), .rebootReq(rebootReq));
   atx_host_model atx_host_model_i (.refClk(refClk), .gpioOut(gpioOut), .gpioOe(gpioOe),
      .altSense(altSense), .gpioIn(gpioIn), .pwrPresses(pwrPresses));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge refClk);
      regWr <= 1'b0;
      @(posedge refClk);
   endtask
   task automatic rd(input logic [3:0] a);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge refClk);
      regRd <= 1'b0;
      #1 rdat = regRdata;
      @(posedge refClk);
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge refClk);
   endtask
   // Bounded wait for an output to reach a level
   task automatic waitFor(input int idx, input logic val, input int lim);
      int n;
      n = 0;
      while (watch[idx] !== val && n < lim) begin
         @(posedge refClk);
         #1 n++;
      end
      chk("wait", {15'h0000, watch[idx]}, {15'h0000, val});
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Cuts a hung run short
   always @(posedge refClk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      tk(3);
      resetn <= 1'b1;
      #1 chk("rstout", {9'h000, blankDisplay, rebootReq, gpioOe}, 16'h0000);
      tk(4);
      for (int i = 0; i < 4; i++) begin
         rd(RV[i][19:16]);
         chk("rstval", rdat, RV[i][15:0]);
      end
      for (int i = 0; i < 7; i++) begin
         wr(ROWS[i][35:32], ROWS[i][31:16]);
         rd(ROWS[i][35:32]);
         chk("reg", rdat, ROWS[i][15:0]);
      end
      $display("test registers done");
      wr(4'h0, 16'h0000);
      cnt = 16'h0000;
      repeat (256) begin
         @(posedge refClk);
         #1 cnt = cnt + {15'h0000, gpioOut[0] === 1'b1};
      end
      chk("pwm", cnt, 16'h0080);
      chk("dir", {11'h000, gpioOe}, 16'h0001);
      for (int v = 0; v < 2; v++) begin
         wr(4'h0, {10'h000, v[0], 5'h00});
         wr(4'h3, 16'h0001);
         #1 chk("cmdon", {14'h0000, gpioOe[2], gpioOut[2]}, {14'h0000, 1'b1, !v[0]});
         waitFor(2, 1'b0, 8 * TC);
         wr(4'h0, {9'h000, v[0], 6'h00});
         wr(4'h3, 16'h0004);
         #1 chk("cmdrst", {14'h0000, gpioOe[3], gpioOut[3]}, {14'h0000, 1'b1, v[0]});
         waitFor(3, 1'b0, 8 * TC);
         tk(TC);
      end
      chk("presses", {8'h00, pwrPresses}, 16'h0002);
      $display("test commands done");
      wr(4'h0, 16'h0009);
      tk(10);
      chk("blank", {15'h0000, blankDisplay}, 16'h0001);
      keyEnter <= 1'b1;
      tk(15 * TC);
      keyEnter <= 1'b0;
      tk(12 * TC);
      chk("early", {15'h0000, gpioOe[2]}, 16'h0000);
      keyEnter <= 1'b1;
      tk(22 * TC);
      chk("onwait", {15'h0000, gpioOe[2]}, 16'h0000);
      waitFor(2, 1'b1, 8 * TC);
      chk("onlvl", {15'h0000, gpioOut[2]}, 16'h0001);
      keyEnter <= 1'b0;
      waitFor(2, 1'b0, 8 * TC);
      wr(4'h0, 16'h0008);
      keyEnter <= 1'b1;
      tk(40 * TC);
      chk("disabled", {15'h0000, gpioOe[2]}, 16'h0000);
      keyEnter <= 1'b0;
      hostSense <= 1'b1;
      tk(4 * TC);
      $display("test power on done");
      wr(4'h0, 16'h0002);
      keyCancel <= 1'b1;
      tk(397 * TC);
      chk("offwait", {15'h0000, gpioOe[2]}, 16'h0000);
      waitFor(2, 1'b1, 8 * TC);
      chk("offlvl", {15'h0000, gpioOut[2]}, 16'h0000);
      tk(480 * TC);
      chk("extend", {15'h0000, gpioOe[2]}, 16'h0001);
      waitFor(2, 1'b0, 24 * TC);
      keyCancel <= 1'b0;
      tk(4 * TC);
      $display("test hard off done");
      wr(4'h0, 16'h0004);
      keyEnter <= 1'b1;
      tk(397 * TC);
      chk("rstwait", {15'h0000, gpioOe[3]}, 16'h0000);
      waitFor(3, 1'b1, 8 * TC);
      chk("rstlvl", {15'h0000, gpioOut[3]}, 16'h0000);
      keyEnter <= 1'b0;
      waitFor(5, 1'b1, 8 * TC);
      $display("test hard reset done");
      wr(4'h0, 16'h0018);
      altSense <= 1'b0;
      tk(10);
      chk("alt", {15'h0000, blankDisplay}, 16'h0001);
      altSense <= 1'b1;
      tk(10);
      chk("alton", {15'h0000, blankDisplay}, 16'h0000);
      rd(4'h4);
      chk("stat", {15'h0000, rdat[0]}, 16'h0001);
      resetn <= 1'b0;
      tk(3);
      resetn <= 1'b1;
      tk(4);
      rd(4'h0);
      chk("rerst", rdat, 16'h0000);
      $display("test sense and reset done");
      print_verdict();
   end
endmodule
bind atx_host_power_keypad_control atx_keypad_chk #(.TICK_CYC(TICK_CYC)) atx_keypad_chk_i (
   .refClk(refClk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regRdata(regRdata), .hostSense(hostSense), .gpioIn(gpioIn),
   .gpioOut(gpioOut), .gpioOe(gpioOe), .blankDisplay(blankDisplay), .rebootReq(rebootReq));

// ---- verilog/atx_host_power_keypad_control.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Power line floats idle, drives on request
// - Reset line floats idle, drives on reset
// - Each keypad function needs its enable
// - Enter 0.25s while off pulses power
// - Cancel 4s while on drives power low, or high if inverted
// - Held cancel extends drive up to 5s
// - Enter 4s while on resets, then reboot
// - Blank display while host sense low
// - Host sense may come from line 1
// - Five lines, direction and PWM output
module atx_host_power_keypad_control #(
   parameter int TICK_CYC = atx_keypad_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic refClk,
   input wire logic resetn,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   // Keys and sense pins
   input wire logic keyEnter,
   input wire logic keyCancel,
   input wire logic hostSense,
   // General-purpose lines
   input wire logic [4:0] gpioIn,
   output logic [4:0] gpioOut,
   output logic [4:0] gpioOe,
   // Module side
   output logic blankDisplay,
   output logic rebootReq
);
   // Sequencer states
   typedef enum logic [2:0] {IDLE, PWR_ON, PWR_OFF, RST_P, REBOOT} seq_t;

   // Whole state of the block
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] stab;
      logic [1:0] keyDeb;
      logic [1:0][3:0] debCnt;
      logic [31:0] divCnt;
      logic tick;
      logic [9:0] enterHold;
      logic [9:0] cancelHold;
      logic [9:0] actTime;
      seq_t seq;
      logic [7:0] ctrl;
      logic [9:0] pulseW;
      logic [4:0] gpioDir;
      logic [4:0][7:0] duty;
      logic [7:0] pwmCnt;
      logic [4:0] gpioOut;
      logic [4:0] gpioOe;
      logic blank;
      logic reboot;
      logic [15:0] rdata;
   } st_t;

   st_t st_reg;
   st_t st_next;

   // Raw pins: enter, cancel, sense, line 1
   logic [3:0] rawIn;
   assign rawIn = {gpioIn[atx_keypad_pkg::GP_SENSE], hostSense, keyCancel, keyEnter};

   // Hold counter that saturates just past its highest threshold
   function automatic logic [9:0] holdStep(input logic [9:0] c, input logic pressed);
      if (!pressed) begin
         holdStep = 10'h000;
      end else if (c > atx_keypad_pkg::EXTRA_T) begin
         holdStep = c;
      end else begin
         holdStep = c + 10'h001;
      end
   endfunction

   // Next-state logic
   always_comb begin
      logic sense;
      logic anyAtx;
      logic drvLvl;
      logic [4:0] pwm;
      st_next = st_reg;
      sense = 1'b0;
      anyAtx = 1'b0;
      drvLvl = 1'b0;
      pwm = 5'h00;
      st_next.reboot = 1'b0;
      st_next.rdata = 16'h0000;
      // Three-stage synchroniser
      st_next.s1 = rawIn;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < 4; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.stab[i] = st_reg.s3[i];
         end
      end
      // Time base divider
      st_next.tick = 1'b0;
      if (st_reg.divCnt >= 32'(TICK_CYC - 1)) begin
         st_next.divCnt = 32'h0000_0000;
         st_next.tick = 1'b1;
      end else begin
         st_next.divCnt = st_reg.divCnt + 32'h0000_0001;
      end
      for (int k = 0; k < 2; k++) begin
         if (st_reg.stab[k] == st_reg.keyDeb[k]) begin
            st_next.debCnt[k] = 4'h0;
         end else if (st_reg.tick) begin
            if (st_reg.debCnt[k] + 4'h1 >= atx_keypad_pkg::DEB_T) begin
               st_next.keyDeb[k] = st_reg.stab[k];
               st_next.debCnt[k] = 4'h0;
            end else begin
               st_next.debCnt[k] = st_reg.debCnt[k] + 4'h1;
            end
         end
      end
      if (!st_reg.keyDeb[0]) begin
         st_next.enterHold = 10'h000;
      end else if (st_reg.tick) begin
         st_next.enterHold = holdStep(st_reg.enterHold, 1'b1);
      end
      if (!st_reg.keyDeb[1]) begin
         st_next.cancelHold = 10'h000;
      end else if (st_reg.tick) begin
         st_next.cancelHold = holdStep(st_reg.cancelHold, 1'b1);
      end
      sense = st_reg.ctrl[atx_keypad_pkg::CB_SENSE1] ? st_reg.stab[3] : st_reg.stab[2];
      anyAtx = |st_reg.ctrl[atx_keypad_pkg::CB_RST:atx_keypad_pkg::CB_PON];
      st_next.blank = st_reg.ctrl[atx_keypad_pkg::CB_BLANK] & ~sense;
      // Register writes
      if (regWr) begin
         case (regAddr)
            atx_keypad_pkg::OFS_CTRL: st_next.ctrl = regWdata[7:0];
            atx_keypad_pkg::OFS_PULSE: st_next.pulseW = regWdata[9:0];
            atx_keypad_pkg::OFS_DIR: st_next.gpioDir = regWdata[4:0];
            default: begin
               for (int i = 0; i < 5; i++) begin
                  if (regAddr == atx_keypad_pkg::OFS_DUTY0 + 4'(i)) begin
                     st_next.duty[i] = regWdata[7:0];
                  end
               end
            end
         endcase
      end
      // Register reads, data in the following cycle only
      if (regRd) begin
         case (regAddr)
            atx_keypad_pkg::OFS_CTRL: st_next.rdata = {8'h00, st_reg.ctrl};
            atx_keypad_pkg::OFS_PULSE: st_next.rdata = {6'h00, st_reg.pulseW};
            atx_keypad_pkg::OFS_DIR: st_next.rdata = {11'h000, st_reg.gpioDir};
            atx_keypad_pkg::OFS_STAT: begin
               // Status word is 7 bits of fields behind 9 pad bits, one pad bit more than a byte
               st_next.rdata = {7'h00, st_reg.seq, st_reg.keyDeb, st_reg.blank, sense};
            end
            default: begin
               for (int i = 0; i < 5; i++) begin
                  if (regAddr == atx_keypad_pkg::OFS_DUTY0 + 4'(i)) begin
                     st_next.rdata = {8'h00, st_reg.duty[i]};
                  end
               end
            end
         endcase
      end
      // Action timer counts ticks inside an action
      if (st_reg.seq != IDLE && st_reg.tick) begin
         st_next.actTime = st_reg.actTime + 10'h001;
      end
      // Sequencer
      case (st_reg.seq)
         IDLE: begin
            st_next.actTime = 10'h000;
            // enter short hold turns host on
            if (st_reg.ctrl[atx_keypad_pkg::CB_PON] && !sense && st_reg.tick &&
                st_reg.enterHold == atx_keypad_pkg::ON_HOLD_T - 10'h001) begin
               st_next.seq = PWR_ON;
            end else if (st_reg.ctrl[atx_keypad_pkg::CB_RST] && sense && st_reg.tick &&
                st_reg.enterHold == atx_keypad_pkg::RST_HOLD_T - 10'h001) begin
               st_next.seq = RST_P;
            end else if (st_reg.ctrl[atx_keypad_pkg::CB_POFF] && sense && st_reg.tick &&
                st_reg.cancelHold == atx_keypad_pkg::OFF_HOLD_T - 10'h001) begin
               st_next.seq = PWR_OFF;
            end else if (regWr && regAddr == atx_keypad_pkg::OFS_CMD) begin
               // Software command drives the same lines
               if (regWdata[atx_keypad_pkg::MB_ON]) begin
                  st_next.seq = PWR_ON;
               end else if (regWdata[atx_keypad_pkg::MB_OFF]) begin
                  st_next.seq = PWR_OFF;
               end else if (regWdata[atx_keypad_pkg::MB_RST]) begin
                  st_next.seq = RST_P;
               end
            end
         end
         PWR_ON, RST_P: begin
            // One pulse width
            if (st_reg.tick && st_reg.actTime + 10'h001 >= st_reg.pulseW) begin
               st_next.seq = (st_reg.seq == RST_P) ? REBOOT : IDLE;
            end
         end
         PWR_OFF: begin
            // at least a pulse, longer while held
            if (st_reg.tick && st_reg.actTime + 10'h001 >= st_reg.pulseW &&
                (!st_reg.keyDeb[1] || st_reg.actTime + 10'h001 >= atx_keypad_pkg::EXTRA_T)) begin
               st_next.seq = IDLE;
            end
         end
         REBOOT: begin
            st_next.reboot = 1'b1;
            st_next.seq = IDLE;
         end
         default: st_next.seq = IDLE;
      endcase
      st_next.pwmCnt = st_reg.pwmCnt + 8'h01;
      for (int i = 0; i < 5; i++) begin
         pwm[i] = st_reg.pwmCnt < st_reg.duty[i];
      end
      st_next.gpioOut = pwm;
      st_next.gpioOe = st_reg.gpioDir;
      if (anyAtx) begin
         st_next.gpioOe[atx_keypad_pkg::GP_PWR] = 1'b0;
         st_next.gpioOe[atx_keypad_pkg::GP_RST] = 1'b0;
      end
      drvLvl = (st_next.seq == PWR_ON) ^ st_reg.ctrl[atx_keypad_pkg::CB_PINV];
      // power line driven at inverted-or-not level
      if (st_next.seq == PWR_ON || st_next.seq == PWR_OFF) begin
         st_next.gpioOe[atx_keypad_pkg::GP_PWR] = 1'b1;
         st_next.gpioOut[atx_keypad_pkg::GP_PWR] = drvLvl;
      end
      // reset line driven low or high
      if (st_next.seq == RST_P) begin
         st_next.gpioOe[atx_keypad_pkg::GP_RST] = 1'b1;
         st_next.gpioOut[atx_keypad_pkg::GP_RST] = st_reg.ctrl[atx_keypad_pkg::CB_RSTHI];
      end
   end

   // State register with synchronous reset
   always_ff @(posedge refClk) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.seq <= IDLE;
         st_reg.ctrl <= atx_keypad_pkg::CTRL_RST;
         st_reg.pulseW <= atx_keypad_pkg::PULSE_RST;
         st_reg.gpioDir <= atx_keypad_pkg::DIR_RST;
         st_reg.duty <= {5{atx_keypad_pkg::DUTY_RST}};
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from state
   assign regRdata = st_reg.rdata;
   assign gpioOut = st_reg.gpioOut;
   assign gpioOe = st_reg.gpioOe;
   assign blankDisplay = st_reg.blank;
   assign rebootReq = st_reg.reboot;
endmodule

// ---- verilog/atx_keypad_pkg.sv ----
package atx_keypad_pkg;
   // Clock and time base
   localparam int CLK_HZ = 20000000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // Documented times in milliseconds
   localparam int ON_HOLD_MS = 250;
   localparam int OFF_HOLD_MS = 4000;
   localparam int RST_HOLD_MS = 4000;
   localparam int EXTRA_MS = 5000;
   localparam int PULSE_MS = 1000;
   localparam int DEB_MS = 20;
   // Times as tick counts
   localparam logic [9:0] ON_HOLD_T = 10'(ON_HOLD_MS / TICK_MS);
   localparam logic [9:0] OFF_HOLD_T = 10'(OFF_HOLD_MS / TICK_MS);
   localparam logic [9:0] RST_HOLD_T = 10'(RST_HOLD_MS / TICK_MS);
   localparam logic [9:0] EXTRA_T = 10'(EXTRA_MS / TICK_MS);
   localparam logic [3:0] DEB_T = 4'((DEB_MS + TICK_MS - 1) / TICK_MS);
   // Register offsets
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_PULSE = 4'h1;
   localparam logic [3:0] OFS_DIR = 4'h2;
   localparam logic [3:0] OFS_CMD = 4'h3;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_DUTY0 = 4'h5;
   // Control field positions
   localparam int CB_PON = 0;
   localparam int CB_POFF = 1;
   localparam int CB_RST = 2;
   localparam int CB_BLANK = 3;
   localparam int CB_SENSE1 = 4;
   localparam int CB_PINV = 5;
   localparam int CB_RSTHI = 6;
   // Command field positions
   localparam int MB_ON = 0;
   localparam int MB_OFF = 1;
   localparam int MB_RST = 2;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [9:0] PULSE_RST = 10'(PULSE_MS / TICK_MS);
   localparam logic [4:0] DIR_RST = 5'h00;
   localparam logic [7:0] DUTY_RST = 8'h00;
   // Line positions
   localparam int GP_SENSE = 1;
   localparam int GP_PWR = 2;
   localparam int GP_RST = 3;
endpackage
